// ===== hw/ppd_pkg.sv
// package for the per-port detect, class and power controller
package ppd_pkg;
    // ************************************************************
    // operating modes and result codes
    // ************************************************************
    localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
    localparam logic [1:0] MODE_MANUAL = 2'h1;
    localparam logic [1:0] MODE_SEMI = 2'h2;
    localparam logic [1:0] MODE_AUTO = 2'h3;

    typedef enum logic [2:0] {
        DET_UNKNOWN = 3'h0,
        DET_SHORT = 3'h1,
        DET_CAP_HIGH = 3'h2,
        DET_R_LOW = 3'h3,
        DET_GOOD = 3'h4,
        DET_R_HIGH = 3'h5,
        DET_OPEN = 3'h6,
        DET_V_RANGE = 3'h7
    } ppd_det_t;

    localparam logic [2:0] CLASS_0 = 3'h0;
    localparam logic [2:0] CLASS_3 = 3'h3;
    localparam logic [2:0] CLASS_4 = 3'h4;

    // current-limit codes for inrush and type 2
    localparam logic [7:0] ILIM_425 = 8'h80;
    localparam logic [7:0] ILIM_850 = 8'hc0;
    // cut thresholds per class for standalone operation
    localparam logic [7:0] ICUT_C1 = 8'h1c;
    localparam logic [7:0] ICUT_C2 = 8'h34;
    localparam logic [7:0] ICUT_C3 = 8'h5e;
    localparam logic [7:0] ICUT_C4 = 8'ha0;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ = 250;
    localparam int BACKOFF_MS = 100;
    localparam int MID_BACKOFF_MS = 2000;
    localparam int CLASS_MS = 12;
    localparam int CUT_MS = 60;
    localparam int LIM_MS = 12;
    localparam int START_MS = 60;
    localparam int MARK_MS = 8;
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
    localparam int CUT_DOWN_DIV = 16;
    // cycles the result synchroniser needs to show a fresh probe
    localparam int MEAS_LAT = 2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_DETECT = 4'h1,
        ST_CLASS = 4'h3,
        ST_MARK = 4'h2,
        ST_CLASS2 = 4'h6,
        ST_BACKOFF = 4'h7,
        ST_INRUSH = 4'h5,
        ST_ON = 4'h4
    } ppd_state_t;

    // analog front-end measurement results
    typedef struct packed {
        logic det_done;
        ppd_det_t det_res;
        logic legacy_cap;
        logic cls_done;
        logic [2:0] cls_res;
        logic over_cut;
        logic over_lim;
        logic over_inrush;
    } ppd_meas_t;

    // host control bits
    typedef struct packed {
        logic [1:0] mode;
        logic det_en;
        logic cls_en;
        logic legacy_en;
        logic hp_en;
        logic two_event_en;
        logic lim_timer_en;
        logic midspan;
        logic [7:0] icut;
        logic [7:0] ilim;
    } ppd_ctrl_t;

    // reported status
    typedef struct packed {
        ppd_det_t det;
        logic [2:0] cls;
        logic second_cls;
        logic power_on;
        logic flt_start;
        logic flt_cut;
        logic flt_lim;
    } ppd_stat_t;
endpackage

// ===== hw/ppd_port.sv
// per-port detect, classify and power sequencer with fault timers
// Contract
// - detection result coded as eight values from unknown to voltage range
// - manual mode idles, runs one detect per host command
// - semi-auto detects repeatedly, updates status, never self-powers
// - semi-auto: after good signature wait 100ms, or 2s in midspan mode
// - semi-auto high power: power-on needs detect good, else start fault
// - auto mode powers after good detect and class, sets thresholds
// - detection off: strap low at reset, shutdown, detect enable clear
// - legacy enable, default clear, reports big capacitance as good
// - class 0 to 4 reported, class 0 treated as class 3
// - classify after good detect, or on manual command, 12ms pulse
// - classification off: strap low at reset, shutdown, enable clear
// - two-event class 4: mark voltage, pause, reclassify, set flag
// - second class cycle only after class 4 with two-event bit set
// - auto mode: class 4 then 0-3 withholds power, restarts detect
// - status holds last class pulse result
// - start timer during inrush; still over limit at expiry: off, fault
// - cut timer up over threshold, down at 1/16 rate, 60ms fault
// - limit timer only when enabled, 12ms fault
// - limit timer disabled: cut timer counts limit events as well
// - limit forced to 425mA during inrush and when off
// - thresholds may change while powered, outside auto mode
// - mode field: 11 auto or reserved, 10 semi, 01 manual, 00 off
module ppd_port
    import ppd_pkg::*;
#(
    parameter int BACKOFF_CYC = BACKOFF_MS * CYC_PER_MS,
    parameter int MID_BACKOFF_CYC = MID_BACKOFF_MS * CYC_PER_MS,
    parameter int CLASS_CYC = CLASS_MS * CYC_PER_MS,
    parameter int MARK_CYC = MARK_MS * CYC_PER_MS,
    parameter int START_CYC = START_MS * CYC_PER_MS,
    parameter int CUT_CYC = CUT_MS * CYC_PER_MS,
    parameter int LIM_CYC = LIM_MS * CYC_PER_MS
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // strap and host
    input wire logic auto_strap_i,
    input wire ppd_ctrl_t ctrl_i,
    input wire logic cmd_detect_i,
    input wire logic cmd_class_i,
    input wire logic cmd_on_i,
    input wire logic cmd_off_i,
    // analog front end
    input wire ppd_meas_t meas_i,
    output logic det_run_o,
    output logic cls_run_o,
    output logic mark_o,
    output logic port_output_pin_o,
    output logic [7:0] ilim_o,
    output logic [7:0] icut_o,
    // status
    output ppd_stat_t stat_o
);
    // ************************************************************
    // strap capture and mode decode
    // ************************************************************
    logic strap_s1_q, strap_s2_q, strap_q, strap_d;
    logic first_q;
    ppd_meas_t m_s1_q, m_q;

    // strap and analog inputs cross two flops before use
    always_ff @(posedge clk_i) begin
        strap_s1_q <= auto_strap_i;
        strap_s2_q <= strap_s1_q;
        m_s1_q <= meas_i;
        m_q <= m_s1_q;
        strap_q <= strap_d;
        first_q <= rst_i;
    end
    // latched only just after reset: later strap changes are ignored
    always_comb begin
        strap_d = first_q ? strap_s2_q : strap_q;
    end

    logic is_auto, is_semi, is_manual, det_ok, cls_ok;
    always_comb begin
        is_auto = (ctrl_i.mode == MODE_AUTO) && strap_q;
        is_semi = ctrl_i.mode == MODE_SEMI;
        is_manual = ctrl_i.mode == MODE_MANUAL;
        det_ok = strap_q || (ctrl_i.det_en &&
            ctrl_i.mode != MODE_SHUTDOWN);
        det_ok = det_ok && (is_auto || is_semi || is_manual);
        cls_ok = strap_q || (ctrl_i.cls_en &&
            ctrl_i.mode != MODE_SHUTDOWN);
        cls_ok = cls_ok && (is_auto || is_semi || is_manual);
    end

    // ************************************************************
    // sequencer
    // ************************************************************
    ppd_state_t st_q, st_d;
    logic [31:0] tmr_q, tmr_d;
    logic [31:0] cut_q, cut_d;
    logic [31:0] lim_q, lim_d;
    logic [3:0] div_q, div_d;
    ppd_stat_t s_q, s_d;
    logic [7:0] auto_cut_q, auto_cut_d, auto_lim_q, auto_lim_d;
    logic det_good, cut_evt, is_off_cmd;

    always_comb begin
        // legacy capacitance counts as good only when enabled
        det_good = m_q.det_res == DET_GOOD ||
            (ctrl_i.legacy_en && m_q.legacy_cap);
        cut_evt = m_q.over_cut ||
            (!ctrl_i.lim_timer_en && m_q.over_lim);
        is_off_cmd = cmd_off_i || ctrl_i.mode == MODE_SHUTDOWN;
    end

    // next state, timers and status
    always_comb begin
        st_d = st_q;
        tmr_d = tmr_q + 32'h1;
        cut_d = cut_q;
        lim_d = lim_q;
        div_d = div_q;
        s_d = s_q;
        s_d.flt_start = 1'b0;
        s_d.flt_cut = 1'b0;
        s_d.flt_lim = 1'b0;
        auto_cut_d = auto_cut_q;
        auto_lim_d = auto_lim_q;
        case (st_q)
            ST_IDLE: begin
                tmr_d = 32'h0;
                if (is_manual && cmd_detect_i && det_ok) begin
                    st_d = ST_DETECT;
                end else if ((is_semi || is_auto) && det_ok) begin
                    st_d = ST_DETECT;
                end else if (is_manual && cmd_class_i && cls_ok) begin
                    st_d = ST_CLASS;
                    s_d.second_cls = 1'b0;
                end
            end
            ST_DETECT: begin
                // the synchroniser still shows the last probe at first
                if (!det_ok) begin
                    st_d = ST_IDLE;
                end else if (m_q.det_done && tmr_q >= MEAS_LAT) begin
                    tmr_d = 32'h0;
                    s_d.det = det_good ? DET_GOOD : m_q.det_res;
                    if (det_good && cls_ok && !is_manual) begin
                        st_d = ST_CLASS;
                    end else if (det_good && is_auto) begin
                        st_d = ST_INRUSH;
                        auto_cut_d = ICUT_C3;
                        auto_lim_d = ILIM_425;
                    end else if (det_good && is_semi) begin
                        st_d = ST_BACKOFF;
                    end else begin
                        // failed probes start over through idle
                        st_d = ST_IDLE;
                    end
                end
            end
            ST_CLASS, ST_CLASS2: begin
                if (tmr_q >= CLASS_CYC - 1 && m_q.cls_done) begin
                    tmr_d = 32'h0;
                    s_d.cls = m_q.cls_res;
                    // the flag always describes the pulse just stored
                    s_d.second_cls = st_q == ST_CLASS2;
                    if (st_q == ST_CLASS && m_q.cls_res == CLASS_4 &&
                        ctrl_i.two_event_en) begin
                        st_d = ST_MARK;
                    end else if (is_auto && st_q == ST_CLASS2 &&
                        m_q.cls_res != CLASS_4) begin
                        st_d = ST_DETECT;
                    end else if (is_auto) begin
                        st_d = ST_INRUSH;
                        // class 0 handled as class 3
                        case (m_q.cls_res)
                            3'h1: auto_cut_d = ICUT_C1;
                            3'h2: auto_cut_d = ICUT_C2;
                            CLASS_4: auto_cut_d = ICUT_C4;
                            default: auto_cut_d = ICUT_C3;
                        endcase
                        auto_lim_d = m_q.cls_res == CLASS_4 ?
                            ILIM_850 : ILIM_425;
                    end else begin
                        st_d = is_manual ? ST_IDLE : ST_BACKOFF;
                    end
                end
            end
            ST_MARK: begin
                if (tmr_q >= MARK_CYC - 1) begin
                    tmr_d = 32'h0;
                    s_d.second_cls = 1'b1;
                    st_d = ST_CLASS2;
                end
            end
            ST_BACKOFF: begin
                if (tmr_q >= (ctrl_i.midspan ? MID_BACKOFF_CYC :
                    BACKOFF_CYC) - 1) begin
                    st_d = ST_IDLE;
                end
            end
            ST_INRUSH: begin
                if (tmr_q >= START_CYC - 1) begin
                    tmr_d = 32'h0;
                    if (m_q.over_inrush) begin
                        s_d.flt_start = 1'b1;
                        st_d = ST_IDLE;
                    end else begin
                        st_d = ST_ON;
                        cut_d = 32'h0;
                        lim_d = 32'h0;
                    end
                end
            end
            ST_ON: begin
                tmr_d = 32'h0;
                div_d = div_q + 4'h1;
                if (cut_evt) begin
                    cut_d = cut_q + 32'h1;
                end else if (cut_q != 32'h0 &&
                    div_q == 4'(CUT_DOWN_DIV - 1)) begin
                    cut_d = cut_q - 32'h1;
                end
                // limit timer restarts whenever current is back under
                lim_d = (ctrl_i.lim_timer_en && m_q.over_lim) ?
                    lim_q + 32'h1 : 32'h0;
                if (cut_d >= CUT_CYC) begin
                    s_d.flt_cut = 1'b1;
                    st_d = ST_IDLE;
                end else if (lim_d >= LIM_CYC) begin
                    s_d.flt_lim = 1'b1;
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        // power-on is taken in any unpowered state, so a host command
        // can cut short a detection in progress
        if (cmd_on_i && st_q != ST_INRUSH && st_q != ST_ON) begin
            if (is_manual || (is_semi &&
                (!ctrl_i.hp_en || s_q.det == DET_GOOD))) begin
                st_d = ST_INRUSH;
                tmr_d = 32'h0;
            end else if (is_semi) begin
                s_d.flt_start = 1'b1;
            end
        end
        if ((st_q == ST_INRUSH || st_q == ST_ON) && is_off_cmd) begin
            st_d = ST_IDLE;
        end
        s_d.power_on = st_d == ST_INRUSH || st_d == ST_ON;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= ST_IDLE;
            tmr_q <= 32'h0;
            cut_q <= 32'h0;
            lim_q <= 32'h0;
            div_q <= 4'h0;
            s_q <= '0;
            auto_cut_q <= ICUT_C3;
            auto_lim_q <= ILIM_425;
        end else begin
            st_q <= st_d;
            tmr_q <= tmr_d;
            cut_q <= cut_d;
            lim_q <= lim_d;
            div_q <= div_d;
            s_q <= s_d;
            auto_cut_q <= auto_cut_d;
            auto_lim_q <= auto_lim_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // outside auto mode thresholds track host writes live, also while powered; the limit only once on
    always_comb begin
        det_run_o = st_q == ST_DETECT;
        cls_run_o = st_q == ST_CLASS || st_q == ST_CLASS2;
        mark_o = st_q == ST_MARK;
        port_output_pin_o = s_q.power_on;
        icut_o = is_auto ? auto_cut_q : ctrl_i.icut;
        ilim_o = (st_q != ST_ON) ? ILIM_425 :
            (is_auto ? auto_lim_q : ctrl_i.ilim);
        stat_o = s_q;
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ilim_inrush_a: assert property (st_q == ST_INRUSH |->
        ilim_o == ILIM_425)
        else $error("limit not forced during inrush");
    semi_start_a: assert property (is_semi && ctrl_i.hp_en &&
        !s_q.power_on && cmd_on_i && s_q.det != DET_GOOD
        |=> s_q.flt_start && !s_q.power_on)
        else $error("semi power without good detect");
    shut_det_a: assert property (ctrl_i.mode == MODE_SHUTDOWN |=>
        !det_run_o)
        else $error("shutdown port still detecting");
    mark_cls_a: assert property (st_q == ST_MARK |->
        $past(cls_run_o) || $past(mark_o))
        else $error("mark without class 4");
    second_flag_a: assert property (st_q == ST_CLASS2 |->
        s_q.second_cls)
        else $error("second class flag missing");
    cut_fault_a: assert property (s_q.flt_cut |-> !s_q.power_on)
        else $error("cut fault left port on");
    lim_off_a: assert property (!ctrl_i.lim_timer_en |=>
        lim_q == 32'h0 || st_q != ST_ON)
        else $error("limit timer ran while disabled");
    start_fault_a: assert property (s_q.flt_start |->
        !port_output_pin_o)
        else $error("start fault left port on");

    pwr_c: cover property (st_q == ST_INRUSH ##1 st_q == ST_ON);
    two_evt_c: cover property (st_q == ST_MARK ##1 st_q == ST_CLASS2);
    cut_c: cover property (s_q.flt_cut);
endmodule

// ===== sim/ppd_pd_model.sv
// behavioural powered device answering the port's probes and loads
module ppd_pd_model
    import ppd_pkg::*;
#(
    parameter int DLY = 3
) (
    // clock
    input wire logic clk_i,
    // drive seen on the cable
    input wire logic det_run_i,
    input wire logic cls_run_i,
    input wire logic mark_i,
    input wire logic pwr_i,
    // device personality set by the bench
    input wire ppd_det_t sig_i,
    input wire logic legacy_i,
    input wire logic [2:0] cls1_i,
    input wire logic [2:0] cls2_i,
    input wire logic [2:0] load_i,
    // measured results
    output ppd_meas_t meas_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // probe timing and result lines
    // ************************************************************
    int cnt_q = 0;
    logic [1:0] run_q = 2'h0;
    logic second_q = 1'b0;

    // restart the count per probe so a class never reuses detect time
    always @(posedge clk_i) begin
        run_q <= {det_run_i, cls_run_i};
        cnt_q <= (run_q != {det_run_i, cls_run_i}) ? 0 : cnt_q + 1;
        if (det_run_i) begin
            second_q <= 1'b0;
        end else if (mark_i) begin
            second_q <= 1'b1;
        end
    end

    // idle result lines carry inverted data so stale values never match
    always_comb begin
        meas_o = '0;
        // the count restarts one edge late, so wait for the delayed bit
        meas_o.det_done = det_run_i && run_q[1] && cnt_q >= DLY;
        meas_o.det_res = meas_o.det_done ? sig_i : ppd_det_t'(~sig_i);
        meas_o.legacy_cap = meas_o.det_done ? legacy_i : ~legacy_i;
        meas_o.cls_done = cls_run_i && run_q[0] && cnt_q >= DLY;
        meas_o.cls_res = second_q ? cls2_i : cls1_i;
        if (!meas_o.cls_done) begin
            meas_o.cls_res = ~meas_o.cls_res;
        end
        // load bits: cut, limit, inrush; only a powered port draws current
        {meas_o.over_cut, meas_o.over_lim, meas_o.over_inrush} =
            pwr_i ? load_i : 3'h0;
    end
endmodule

// ===== sim/ppd_port_tb.sv
// self-checking bench for the port sequencer against a device model
module ppd_port_tb
    import ppd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // short timer settings and stimulus
    // ************************************************************
    localparam int BO = 40;
    localparam int MB = 80;
    localparam int CT = 30;
    localparam int LM = 12;
    localparam int ST = 20;
    typedef struct packed {
        ppd_det_t sig;
        logic leg;
        logic leg_en;
        ppd_det_t exp;
    } ppd_row_t;
    ppd_row_t rows[10] = '{
        '{DET_UNKNOWN, 0, 0, DET_UNKNOWN}, '{DET_SHORT, 0, 0, DET_SHORT},
        '{DET_CAP_HIGH, 0, 0, DET_CAP_HIGH}, '{DET_R_LOW, 0, 0, DET_R_LOW},
        '{DET_GOOD, 0, 0, DET_GOOD}, '{DET_R_HIGH, 0, 0, DET_R_HIGH},
        '{DET_OPEN, 0, 0, DET_OPEN}, '{DET_V_RANGE, 0, 0, DET_V_RANGE},
        '{DET_CAP_HIGH, 1, 0, DET_CAP_HIGH}, '{DET_CAP_HIGH, 1, 1, DET_GOOD}};
    logic clk_i = 0, rst_i = 1, strap = 0, leg = 0, run_q = 0;
    logic s_start = 0, s_cut = 0, s_lim = 0, s_on = 0;
    logic [3:0] cmd_q = 4'h0;
    logic [2:0] c1 = 3'h0, c2 = 3'h0, load = 3'h0;
    logic det_run, cls_run, mark, pin;
    logic [7:0] ilim, icut;
    ppd_ctrl_t ctrl;
    ppd_meas_t meas;
    ppd_stat_t stat;
    ppd_det_t sig = DET_OPEN;
    int err_count = 0, n_compared = 0, cyc = 0, starts = 0, t0 = 0;
    int gap = 0, snap;

    ppd_port #(.BACKOFF_CYC(BO), .MID_BACKOFF_CYC(MB), .CLASS_CYC(10),
        .MARK_CYC(5), .START_CYC(ST), .CUT_CYC(CT), .LIM_CYC(LM)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .auto_strap_i(strap), .ctrl_i(ctrl),
        .cmd_detect_i(cmd_q[0]), .cmd_class_i(cmd_q[1]),
        .cmd_on_i(cmd_q[2]), .cmd_off_i(cmd_q[3]), .meas_i(meas),
        .det_run_o(det_run), .cls_run_o(cls_run), .mark_o(mark),
        .port_output_pin_o(pin), .ilim_o(ilim), .icut_o(icut),
        .stat_o(stat));
    ppd_pd_model u_pd (.clk_i(clk_i), .det_run_i(det_run),
        .cls_run_i(cls_run), .mark_i(mark), .pwr_i(pin), .sig_i(sig),
        .legacy_i(leg), .cls1_i(c1), .cls2_i(c2), .load_i(load),
        .meas_o(meas));

    // 250 MHz clock
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic complete_run();
        if (err_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one-cycle command: bit 0 detect, 1 class, 2 on, 3 off
    task automatic cmd(input logic [3:0] c);
        @(posedge clk_i);
        cmd_q <= c;
        @(posedge clk_i);
        cmd_q <= 4'h0;
    endtask

    task automatic clr();
        s_start <= 1'b0;
        s_cut <= 1'b0;
        s_lim <= 1'b0;
        s_on <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        tick(20);
        rst_i <= 1'b0;
        tick(2);
    endtask

    // fault pulses are one cycle wide, so latch them; also time detects
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        run_q <= det_run;
        if (det_run && !run_q) begin
            starts <= starts + 1;
            gap <= cyc - t0;
            t0 <= cyc;
        end
        if (stat.flt_start) s_start <= 1'b1;
        if (stat.flt_cut) s_cut <= 1'b1;
        if (stat.flt_lim) s_lim <= 1'b1;
        if (pin) s_on <= 1'b1;
        if (cyc == 5000) begin
            err_count++;
            complete_run();
        end
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        ctrl = '0;
        ctrl.mode = MODE_MANUAL;
        ctrl.det_en = 1'b1;
        ctrl.cls_en = 1'b1;
        ctrl.icut = 8'h40;
        ctrl.ilim = ILIM_850;
        do_reset();
        chk(stat, '0);
        chk(ilim, ILIM_425);
        foreach (rows[i]) begin
            sig <= rows[i].sig;
            leg <= rows[i].leg;
            ctrl.legacy_en <= rows[i].leg_en;
            cmd(4'h1);
            tick(20);
            chk(stat.det, rows[i].exp);
            chk(starts, i + 1);
        end
        c1 <= 3'h2;
        cmd(4'h2);
        tick(30);
        chk(stat.cls, 3'h2);
        cmd(4'h4);
        tick(5);
        chk(ilim, ILIM_425);
        tick(ST + 5);
        chk(pin, 1);
        chk(ilim, ILIM_850);
        ctrl.icut <= 8'h55;
        tick(2);
        chk(icut, 8'h55);
        // cut timer: up 20, down 32 cycles at 1/16, then trips 12 later
        load <= 3'h4;
        tick(20);
        load <= 3'h0;
        tick(32);
        load <= 3'h4;
        tick(6);
        chk(pin, 1);
        tick(14);
        chk(pin, 0);
        chk(s_cut, 1);
        chk(ilim, ILIM_425);
        load <= 3'h0;
        ctrl.lim_timer_en <= 1'b1;
        cmd(4'h4);
        tick(ST + 5);
        clr();
        load <= 3'h2;
        tick(LM + 6);
        chk({pin, s_lim}, 2'b01);
        load <= 3'h0;
        ctrl.lim_timer_en <= 1'b0;
        cmd(4'h4);
        tick(ST + 5);
        clr();
        load <= 3'h2;
        tick(LM + 6);
        chk(pin, 1);
        tick(CT);
        chk({pin, s_cut, s_lim}, 3'b010);
        load <= 3'h1;
        cmd(4'h4);
        tick(ST + 8);
        chk({pin, s_start}, 2'b01);
        load <= 3'h0;
        ctrl.mode <= MODE_SHUTDOWN;
        snap = starts;
        tick(60);
        chk(starts, snap);
        // semi-auto with detection disabled, then enabled
        ctrl <= '{mode: MODE_SEMI, hp_en: 1, ilim: ILIM_850, default: 0};
        sig <= DET_R_LOW;
        tick(60);
        chk(starts, snap);
        ctrl.det_en <= 1'b1;
        tick(150);
        chk(starts > snap + 1, 1);
        chk(stat.det, DET_R_LOW);
        clr();
        cmd(4'h4);
        tick(10);
        chk({pin, s_start}, 2'b01);
        sig <= DET_GOOD;
        tick(150);
        chk({gap >= BO, gap < MB, s_on}, 3'b110);
        ctrl.midspan <= 1'b1;
        tick(300);
        chk(gap >= MB, 1);
        cmd(4'h4);
        tick(ST + 10);
        chk(pin, 1);
        cmd(4'h8);
        tick(5);
        chk(pin, 0);
        // strap high: standalone powering with two-event class
        strap <= 1'b1;
        c1 <= CLASS_4;
        c2 <= CLASS_4;
        ctrl <= '{mode: MODE_AUTO, cls_en: 1, hp_en: 1, two_event_en: 1,
            default: 0};
        do_reset();
        tick(150);
        chk({pin, stat.second_cls}, 2'b11);
        chk({icut, ilim}, {ICUT_C4, ILIM_850});
        c2 <= 3'h2;
        do_reset();
        clr();
        snap = starts;
        tick(100);
        // look just after a restart, while the invalid pair is on show
        @(posedge det_run);
        tick(2);
        chk({s_on, stat.second_cls, stat.cls}, 5'b01010);
        chk(starts > snap + 1, 1);
        // class 0 alone: type 1 power, class 3 thresholds, one pulse
        c1 <= CLASS_0;
        do_reset();
        tick(100);
        chk({pin, stat.second_cls}, 2'b10);
        chk({icut, ilim}, {ICUT_C3, ILIM_425});
        complete_run();
    end
endmodule
